/* rtl/converter_calibration_control.sv */
// register bank and sequencing for oscillator tuning and converter calibration
// Operation
// - three-bit settle setting, reset four, sets wait after each trim change.
// - tuning starts only when pll hold reset returns to zero while enabled.
// - engine adjusts trim itself until oscillator is centred.
// - done flag reads one after tuning, or when tuning is disabled.
// - run bit high runs calibration, low holds it in reset; resets one.
// - clearing run bit also resets processing and serial clock dividers.
// - bit three enables background offset trim; needs background on, not enforced here: gated by run bit only, not by bit one.
// - bit two enables foreground offset trim; needs foreground run, not enforced here: gated by run bit only, not by bit zero.
// - bit one enables background calibration; reset zero.
// - bit zero resets one; set runs foreground, clear skips it.
`timescale 1ns/1ps
`default_nettype none
`include "cal_ctrl_defs.svh"
module converter_calibration_control
  import cal_ctrl_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata,
  input  wire logic       clock_pll_hold_reset,
  input  wire logic       osc_too_fast,
  input  wire logic       trim_wr,
  input  wire logic [6:0] trim_wdata,
  output var  logic [6:0] oscillator_frequency_trim,
  output var  logic       tuning_active,
  output var  logic       cal_hold_reset,
  output var  logic       divider_reset,
  output var  logic       foreground_calibration_run,
  output var  logic       background_calibration_on,
  output var  logic       foreground_offset_trim_on,
  output var  logic       background_offset_trim_on,
  output var  logic       fg_cal_done
);

  state_t q_ff;
  state_t nxt_q;

  ////////////////////////////////////////////////////////////////////////////
  // settle wait length
  logic [15:0] settle_cyc;
  assign settle_cyc = 16'(({13'h0000, q_ff.cfg.settle} + 16'h0001)
                      * 16'(`SETTLE_UNIT_CYC));

  logic wr_tctl;
  logic wr_run;
  logic wr_mode;
  assign wr_tctl = reg_wr && (reg_addr == `OSC_TUNE_CTRL_ADDR);
  assign wr_run  = reg_wr && (reg_addr == `CAL_RUN_CTRL_ADDR);
  assign wr_mode = reg_wr && (reg_addr == `CAL_MODE_CFG_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_q = q_ff;
    nxt_q.pll_rst_q = clock_pll_hold_reset;
    // register writes; reserved bits are not stored
    if (wr_tctl) begin
      nxt_q.cfg.settle  = reg_wdata[`STL_MSB:`STL_LSB];
      nxt_q.cfg.tune_en = reg_wdata[`TUNE_EN_BIT];
    end
    if (wr_run) begin
      nxt_q.cfg.run = reg_wdata[`RUN_BIT];
    end
    if (wr_mode) begin
      nxt_q.cfg.mode = reg_wdata[3:0];
    end
    // trim written by software only when engine is not tuning
    if (trim_wr && (q_ff.tstate != TUNE_SETTLE)) begin
      nxt_q.trim = trim_wdata;
    end

    // oscillator tuning engine
    unique case (q_ff.tstate)
      TUNE_IDLE: begin
        if (!q_ff.cfg.tune_en) begin
          nxt_q.done = 1'b1;
        end else if (clock_pll_hold_reset) begin
          nxt_q.done = 1'b0;
        end else if (q_ff.pll_rst_q) begin
          // falling edge of hold reset starts a binary search
          nxt_q.tstate   = TUNE_SETTLE;
          nxt_q.trim     = 7'h40;
          nxt_q.step     = 7'h20;
          nxt_q.wait_cnt = settle_cyc;
          nxt_q.done     = 1'b0;
        end
      end
      TUNE_SETTLE: begin
        if (clock_pll_hold_reset) begin
          nxt_q.tstate = TUNE_IDLE;
          nxt_q.done   = !q_ff.cfg.tune_en;
        end else if (q_ff.wait_cnt > 16'h0001) begin
          nxt_q.wait_cnt = q_ff.wait_cnt - 16'h0001;
        end else begin
          // step trim toward centre after settling
          if (osc_too_fast) begin
            nxt_q.trim = q_ff.trim - q_ff.step;
          end else begin
            nxt_q.trim = q_ff.trim + q_ff.step;
          end
          nxt_q.wait_cnt = settle_cyc;
          nxt_q.step     = {1'b0, q_ff.step[6:1]};
          if (q_ff.step == 7'h00) begin
            nxt_q.trim   = q_ff.trim;
            nxt_q.tstate = TUNE_DONE;
            nxt_q.done   = 1'b1;
          end
        end
      end
      TUNE_DONE: begin
        if (clock_pll_hold_reset) begin
          nxt_q.tstate = TUNE_IDLE;
          nxt_q.done   = !q_ff.cfg.tune_en;
        end
      end
    endcase

    // foreground calibration timer held while run bit is low
    if (!q_ff.cfg.run) begin
      nxt_q.fg_cnt  = `FG_CAL_CYC;
      nxt_q.fg_done = 1'b0;
    end else if (!q_ff.cfg.mode[`FG_BIT]) begin
      nxt_q.fg_done = 1'b1;
    end else if (q_ff.fg_cnt != 16'h0000) begin
      nxt_q.fg_cnt = q_ff.fg_cnt - 16'h0001;
    end else begin
      nxt_q.fg_done = 1'b1;
    end

    // read data
    nxt_q.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `OSC_TUNE_CTRL_ADDR: begin
          nxt_q.rdata = {1'b0, q_ff.cfg.settle, 3'b000, q_ff.cfg.tune_en};
        end
        `OSC_TUNE_STAT_ADDR: begin
          nxt_q.rdata = {7'h00, q_ff.done};
        end
        `CAL_RUN_CTRL_ADDR: begin
          nxt_q.rdata = {7'h00, q_ff.cfg.run};
        end
        `CAL_MODE_CFG_ADDR: begin
          nxt_q.rdata = {4'h0, q_ff.cfg.mode};
        end
        default: begin
          nxt_q.rdata = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q_ff.cfg.settle  <= 3'(`OSC_TUNE_CTRL_RST >> `STL_LSB);
      q_ff.cfg.tune_en <= 1'b0;
      q_ff.cfg.run     <= 1'(`CAL_RUN_CTRL_RST);
      q_ff.cfg.mode    <= 4'(`CAL_MODE_CFG_RST);
      q_ff.tstate      <= TUNE_IDLE;
      q_ff.done        <= 1'b0;
      q_ff.trim        <= `TRIM_RST;
      q_ff.step        <= 7'h00;
      q_ff.wait_cnt    <= 16'h0000;
      q_ff.pll_rst_q   <= 1'b0;
      q_ff.fg_cnt      <= `FG_CAL_CYC;
      q_ff.fg_done     <= 1'b0;
      q_ff.rdata       <= 8'h00;
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata                  = q_ff.rdata;
  assign oscillator_frequency_trim  = q_ff.trim;
  assign tuning_active              = (q_ff.tstate == TUNE_SETTLE);
  assign cal_hold_reset             = !q_ff.cfg.run;
  assign divider_reset              = !q_ff.cfg.run;

  // every mode bit is gated off while calibration is held
  logic [3:0] mode_on;
  for (genvar b = 0; b < 4; b++) begin : g_mode_gate
    assign mode_on[b] = q_ff.cfg.mode[b] && q_ff.cfg.run;
  end
  assign foreground_calibration_run = mode_on[`FG_BIT];
  assign background_calibration_on  = mode_on[`BG_BIT];
  assign foreground_offset_trim_on  = mode_on[`FGOS_BIT];
  assign background_offset_trim_on  = mode_on[`BGOS_BIT];
  assign fg_cal_done                = q_ff.fg_done;

endmodule
`default_nettype wire

/* rtl/cal_ctrl_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef CAL_CTRL_DEFS_SVH
`define CAL_CTRL_DEFS_SVH
`define OSC_TUNE_CTRL_ADDR   8'h5d
`define OSC_TUNE_STAT_ADDR   8'h5e
`define CAL_RUN_CTRL_ADDR    8'h61
`define CAL_MODE_CFG_ADDR    8'h62
`define OSC_TUNE_CTRL_RST    8'h40
`define CAL_RUN_CTRL_RST     8'h01
`define CAL_MODE_CFG_RST     8'h01
`define TRIM_RST             7'h00
`define STL_LSB              4
`define STL_MSB              6
`define TUNE_EN_BIT          0
`define RUN_BIT              0
`define BGOS_BIT             3
`define FGOS_BIT             2
`define BG_BIT               1
`define FG_BIT               0
`define SETTLE_UNIT_NS       160
`define SETTLE_UNIT_CYC      ((`SETTLE_UNIT_NS + 9) / 10)
`define FG_CAL_CYC           16'h0040
`endif

/* rtl/cal_ctrl_pkg.sv */
// types for the converter calibration control bank
package cal_ctrl_pkg;
  typedef enum logic [2:0] {
    TUNE_IDLE   = 3'b001,
    TUNE_SETTLE = 3'b010,
    TUNE_DONE   = 3'b100
  } tune_state_t;

  typedef struct packed {
    logic [2:0] settle;
    logic       tune_en;
    logic       run;
    logic [3:0] mode;
  } cfg_t;

  typedef struct packed {
    cfg_t        cfg;
    tune_state_t tstate;
    logic        done;
    logic [6:0]  trim;
    logic [6:0]  step;
    logic [15:0] wait_cnt;
    logic        pll_rst_q;
    logic [15:0] fg_cnt;
    logic        fg_done;
    logic [7:0]  rdata;
  } state_t;
endpackage

/* sim/cal_ctrl_asserts.sv */
// port checker for the calibration control bank
`timescale 1ns/1ps
`default_nettype none
module cal_ctrl_checker (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       clock_pll_hold_reset,
  input wire logic       osc_too_fast,
  input wire logic       trim_wr,
  input wire logic [6:0] trim_wdata,
  input wire logic [6:0] oscillator_frequency_trim,
  input wire logic       tuning_active,
  input wire logic       cal_hold_reset,
  input wire logic       divider_reset,
  input wire logic       foreground_calibration_run,
  input wire logic       background_calibration_on,
  input wire logic       foreground_offset_trim_on,
  input wire logic       background_offset_trim_on,
  input wire logic       fg_cal_done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  div_follow_a: assert property (
    divider_reset == cal_hold_reset)
    else $error("divider reset differs from hold");
  run_gate_a: assert property (
    (foreground_calibration_run || background_calibration_on)
      |-> !cal_hold_reset)
    else $error("calibration on while held");
  offset_gate_a: assert property (
    (foreground_offset_trim_on || background_offset_trim_on)
      |-> !cal_hold_reset)
    else $error("offset trim on while held");
  tune_start_a: assert property (
    $rose(tuning_active)
      |-> !$past(clock_pll_hold_reset) && $past(clock_pll_hold_reset, 2))
    else $error("tuning began without pll release");
  trim_hold_a: assert property (
    !tuning_active && !$past(tuning_active) && !$past(trim_wr)
      |-> $stable(oscillator_frequency_trim))
    else $error("trim moved while idle");
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  status_fmt_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h5e
      |-> reg_rdata[7:1] == 7'h00
          && !($past(tuning_active) && reg_rdata[0]))
    else $error("status read wrong");
  unmapped_read_a: assert property (
    $past(reg_rd)
      && !($past(reg_addr) inside {8'h5d, 8'h5e, 8'h61, 8'h62})
      |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  run_write_a: assert property (
    reg_wr && reg_addr == 8'h61
      |=> cal_hold_reset == !$past(reg_wdata[0])
          && divider_reset == !$past(reg_wdata[0]))
    else $error("run bit write not applied");
  mode_write_a: assert property (
    reg_wr && reg_addr == 8'h62 && !cal_hold_reset
      |=> foreground_calibration_run == $past(reg_wdata[0])
          && background_calibration_on == $past(reg_wdata[1]))
    else $error("mode bits not applied");
  tune_c: cover property ($rose(tuning_active));
  fg_c: cover property ($rose(fg_cal_done));
  held_c: cover property ($rose(cal_hold_reset));
endmodule
bind converter_calibration_control cal_ctrl_checker u_cal_ctrl_checker (
  .mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .clock_pll_hold_reset(clock_pll_hold_reset), .osc_too_fast(osc_too_fast),
  .trim_wr(trim_wr), .trim_wdata(trim_wdata),
  .oscillator_frequency_trim(oscillator_frequency_trim),
  .tuning_active(tuning_active), .cal_hold_reset(cal_hold_reset),
  .divider_reset(divider_reset),
  .foreground_calibration_run(foreground_calibration_run),
  .background_calibration_on(background_calibration_on),
  .foreground_offset_trim_on(foreground_offset_trim_on),
  .background_offset_trim_on(background_offset_trim_on),
  .fg_cal_done(fg_cal_done));
`default_nettype wire

/* sim/tb.sv */
// register-level testbench for the calibration control bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin \
  samples_checked++; \
  if ((s) !== (e)) begin \
    fail_count++; \
    $display("wrong value %s exp %h got %h", n, e, s); \
  end \
end
module tb;
  logic       mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, hold = 0, twr = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rd, d;
  logic [6:0] twd = 7'h00, trim;
  logic       fast = 0;
  logic       act, chr, dvr, fgr, bgr, fgo, bgo, fgd;
  int         fail_count = 0, samples_checked = 0, i;
  always #5 mclk = ~mclk;
  converter_calibration_control u_converter_calibration_control (
    .mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rd),
    .clock_pll_hold_reset(hold), .osc_too_fast(fast), .trim_wr(twr),
    .trim_wdata(twd), .oscillator_frequency_trim(trim), .tuning_active(act),
    .cal_hold_reset(chr), .divider_reset(dvr),
    .foreground_calibration_run(fgr), .background_calibration_on(bgr),
    .foreground_offset_trim_on(fgo), .background_offset_trim_on(bgo),
    .fg_cal_done(fgd));
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk) addr = a;
    wd = v;
    reg_wr = 1;
    @(negedge mclk) reg_wr = 0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk) addr = a;
    reg_rd = 1;
    @(negedge mclk) reg_rd = 0;
    `CHK("register", e, rd)
  endtask
  task finish_test;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_tune(output int n);
    for (n = 0; n < 500 && act !== 1'b0; n++) @(negedge mclk);
    if (act !== 1'b0) begin
      fail_count++;
      finish_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge mclk);
    rstn = 1;
    rchk(8'h5d, 8'h40);
    rchk(8'h5e, 8'h01);
    rchk(8'h61, 8'h01);
    rchk(8'h62, 8'h01);
    rchk(8'h00, 8'h00);
    $display("test reset values done");
    wr(8'h62, 8'h0f);
    rchk(8'h62, 8'h0f);
    `CHK("outputs", 4'hf, {fgr, bgr, fgo, bgo})
    wr(8'h61, 8'h00);
    `CHK("held", 6'b110000, {chr, dvr, fgr, bgr, fgo, bgo})
    wr(8'h62, 8'h01);
    wr(8'h61, 8'h01);
    `CHK("fg early", 1'b0, fgd)
    repeat (64) @(negedge mclk);
    `CHK("fg busy", 1'b0, fgd)
    repeat (6) @(negedge mclk);
    `CHK("fg run", 1'b1, fgd)
    wr(8'h61, 8'h00);
    wr(8'h62, 8'h00);
    wr(8'h61, 8'h01);
    repeat (2) @(negedge mclk);
    `CHK("fg skip", 1'b1, fgd)
    $display("test calibration control done");
    hold = 1;
    wr(8'h5d, 8'h01);
    rchk(8'h5d, 8'h01);
    rchk(8'h5e, 8'h00);
    @(negedge mclk) hold = 0;
    repeat (2) @(negedge mclk);
    `CHK("active", 1'b1, act)
    twd = 7'h05;
    twr = 1;
    @(negedge mclk) twr = 0;
    wait_tune(i);
    `CHK("settle", 32'h0000_006e, i)
    `CHK("trim", 7'h7f, trim)
    rchk(8'h5e, 8'h01);
    twr = 1;
    @(negedge mclk) twr = 0;
    @(negedge mclk);
    `CHK("trim write", 7'h05, trim)
    hold = 1;
    fast = 1;
    wr(8'h5d, 8'h11);
    rchk(8'h5d, 8'h11);
    rchk(8'h5e, 8'h00);
    @(negedge mclk) hold = 0;
    repeat (2) @(negedge mclk);
    `CHK("active again", 1'b1, act)
    wait_tune(i);
    `CHK("settle long", 32'h0000_00df, i)
    `CHK("trim low", 7'h01, trim)
    wr(8'h61, 8'h00);
    @(negedge mclk) rstn = 0;
    @(negedge mclk);
    `CHK("reset outputs", 9'h000, {chr, act, trim})
    rstn = 1;
    rchk(8'h5e, 8'h01);
    rchk(8'h61, 8'h01);
    $display("test oscillator tuning done");
    finish_test();
  end
endmodule
`default_nettype wire
